// ---- hdl/plc_pkg.sv ----
`default_nettype none
package plc_pkg;
    // Register byte offsets
    localparam logic [7:0] PLC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] PLC_OFF_STATUS = 8'h04;
    localparam logic [7:0] PLC_OFF_IRQ_ST = 8'h08;
    localparam logic [7:0] PLC_OFF_IRQ_MK = 8'h0C;
    // Control field positions
    localparam int PLC_CTRL_FAULT_EN   = 0;
    localparam int PLC_CTRL_LOS_EN     = 1;
    localparam int PLC_CTRL_PASSIVE    = 2;
    localparam int PLC_CTRL_RATE_EN_RX = 3;
    localparam int PLC_CTRL_RATE_EN_TX = 4;
    localparam int PLC_CTRL_FAULT_CLR  = 5;
    // Interrupt/status bit positions
    localparam int PLC_EV_FAULT     = 0;
    localparam int PLC_EV_LOS       = 1;
    localparam int PLC_EV_TX_CHANGE = 2;
    localparam int PLC_EV_RATE      = 3;
    localparam int PLC_EV_W         = 4;
    // Reset values
    localparam logic [5:0] PLC_CTRL_RST = 6'h1B;
    localparam logic [3:0] PLC_MASK_RST = 4'h0;
    // Synchroniser reset: off request high, all other pins low
    localparam logic [4:0] PLC_PIN_RST  = 5'h10;
    // AXI response codes
    localparam logic [1:0] PLC_RESP_OK     = 2'h0;
    localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       tx_off_request;
        logic       receive_rate_select;
        logic       transmit_rate_select;
        logic       laser_fault;
        logic       optical_below_level;
    } plc_pins_in_t;

    typedef struct packed {
        logic       fault_pull_low_oe;
        logic       fault_out;
        logic       los_pull_low_oe;
        logic       los_out;
        logic       missing_tie_low_oe;
        logic       missing_out;
        logic       laser_enable;
        logic       rx_high_rate;
        logic       tx_high_rate;
    } plc_pins_out_t;
endpackage
`default_nettype wire

// ---- hdl/plc_sync.sv ----
`default_nettype none
module plc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } plc_sync_st_t;

    plc_sync_st_t st;
    plc_sync_st_t next_st;

    // Reset value is a constant at every use
    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st <= '{s1: rst_val_in, s2: rst_val_in};
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule
`default_nettype wire

// ---- hdl/plc_ctrl.sv ----
`default_nettype none
// Summary of operation
// - Fault flag high on laser fault
// - No fault reporting: flag held low
// - Fault flag open drain, host pulls up
// - Off request high or open: laser off
// - Passive cable may ignore off request
// - Off request low: transmitter runs normally
// - Rate selects read low when undriven
// - Receive rate select optionally steers receiver
// - Transmit rate select optionally steers transmitter
// - Receive select high: above 4.25 GBd
// - Transmit select high: above 4.25 GBd
// - Module-missing flag tied to ground
// - Signal-lost flag high below optical level
module plc_ctrl
    import plc_pkg::*;
(
    input  wire logic                 mclk_in,
    input  wire logic                 rst_n_in,
    input  wire plc_pkg::plc_pins_in_t pins_in,
    output plc_pkg::plc_pins_out_t    pins_out,
    output logic                      irq_out,
    input  wire logic [7:0]           s_axi_awaddr_in,
    input  wire logic                 s_axi_awvalid_in,
    output logic                      s_axi_awready_out,
    input  wire logic [31:0]          s_axi_wdata_in,
    input  wire logic [3:0]           s_axi_wstrb_in,
    input  wire logic                 s_axi_wvalid_in,
    output logic                      s_axi_wready_out,
    output logic [1:0]                s_axi_bresp_out,
    output logic                      s_axi_bvalid_out,
    input  wire logic                 s_axi_bready_in,
    input  wire logic [7:0]           s_axi_araddr_in,
    input  wire logic                 s_axi_arvalid_in,
    output logic                      s_axi_arready_out,
    output logic [31:0]               s_axi_rdata_out,
    output logic [1:0]                s_axi_rresp_out,
    output logic                      s_axi_rvalid_out,
    input  wire logic                 s_axi_rready_in
);
    import plc_pkg::*;

    typedef struct packed {
        logic [5:0]          ctrl;
        logic [PLC_EV_W-1:0] irq_st;
        logic [PLC_EV_W-1:0] irq_mk;
        logic                fault_latched;
        logic                prev_fault;
        logic                prev_los;
        logic                prev_laser;
        logic [1:0]          prev_rate;
        logic                aw_held;
        logic [7:0]          aw_addr;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        plc_pins_out_t       pins;
    } plc_st_t;

    plc_st_t st;
    plc_st_t next_st;

    logic [4:0] pin_sync;
    logic       tx_off_s;
    logic       rx_rate_s;
    logic       tx_rate_s;
    logic       fault_s;
    logic       below_s;

    // Pins pass two flops; off request resets to off, rates to low
    plc_sync #(
        .W(5)
    ) plc_sync_inst (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({pins_in.tx_off_request, pins_in.receive_rate_select,
                     pins_in.transmit_rate_select, pins_in.laser_fault,
                     pins_in.optical_below_level}),
        .rst_val_in(PLC_PIN_RST),
        .sync_out  (pin_sync)
    );
    assign {tx_off_s, rx_rate_s, tx_rate_s, fault_s, below_s} = pin_sync;

    logic            do_write;
    logic [31:0]     wr_mask;
    logic [PLC_EV_W-1:0] ev;
    logic            fault_now;
    logic            laser_on;

    always_comb begin
        next_st  = st;
        do_write = st.aw_held && st.w_held && !st.bvalid;
        wr_mask  = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}},
                    {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};

        // Fault stays latched until software clears it, so a
        // brief fault cannot re-enable the laser by itself
        fault_now = st.ctrl[PLC_CTRL_FAULT_EN] && (fault_s || st.fault_latched);
        next_st.fault_latched = st.ctrl[PLC_CTRL_FAULT_EN] && (fault_s || st.fault_latched);

        // Passive mode ignores the off request entirely
        laser_on = st.ctrl[PLC_CTRL_PASSIVE] ? 1'b1 : !tx_off_s;
        laser_on = laser_on && !fault_now;

        next_st.pins.fault_out          = 1'b0;
        next_st.pins.fault_pull_low_oe  = !fault_now;
        next_st.pins.los_out            = 1'b0;
        next_st.pins.los_pull_low_oe    = !(st.ctrl[PLC_CTRL_LOS_EN] && below_s);
        next_st.pins.missing_out        = 1'b0;
        next_st.pins.missing_tie_low_oe = 1'b1;
        next_st.pins.laser_enable       = laser_on;
        // Undriven selects read low via pull-down, i.e. up to 4.25 GBd
        next_st.pins.rx_high_rate = st.ctrl[PLC_CTRL_RATE_EN_RX] && rx_rate_s;
        next_st.pins.tx_high_rate = st.ctrl[PLC_CTRL_RATE_EN_TX] && tx_rate_s;

        ev = '0;
        ev[PLC_EV_FAULT]     = fault_now && !st.prev_fault;
        ev[PLC_EV_LOS]       = next_st.pins.los_pull_low_oe != st.prev_los;
        ev[PLC_EV_TX_CHANGE] = laser_on != st.prev_laser;
        ev[PLC_EV_RATE]      = {rx_rate_s, tx_rate_s} != st.prev_rate;
        next_st.prev_fault = fault_now;
        next_st.prev_los   = next_st.pins.los_pull_low_oe;
        next_st.prev_laser = laser_on;
        next_st.prev_rate  = {rx_rate_s, tx_rate_s};

        // Write channels taken in either order
        if (s_axi_awvalid_in && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata_in;
            next_st.w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = PLC_RESP_OK;
            case ({st.aw_addr[7:2], 2'b00})
                PLC_OFF_CTRL: begin
                    next_st.ctrl = (st.ctrl & ~wr_mask[5:0]) | (st.w_data[5:0] & wr_mask[5:0]);
                    if (st.w_strb[0] && st.w_data[PLC_CTRL_FAULT_CLR]) begin
                        next_st.fault_latched = fault_s && st.ctrl[PLC_CTRL_FAULT_EN];
                    end
                    next_st.ctrl[PLC_CTRL_FAULT_CLR] = 1'b0;
                end
                PLC_OFF_STATUS: begin
                end
                PLC_OFF_IRQ_ST: begin
                    if (st.w_strb[0]) begin
                        next_st.irq_st = st.irq_st & ~st.w_data[PLC_EV_W-1:0];
                    end
                end
                PLC_OFF_IRQ_MK: begin
                    if (st.w_strb[0]) begin
                        next_st.irq_mk = st.w_data[PLC_EV_W-1:0];
                    end
                end
                default: begin
                    next_st.bresp = PLC_RESP_SLVERR;
                end
            endcase
        end
        // Set wins over clear
        next_st.irq_st = next_st.irq_st | ev;
        if (st.bvalid && s_axi_bready_in) begin
            next_st.bvalid = 1'b0;
        end

        if (s_axi_arvalid_in && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = PLC_RESP_OK;
            case ({s_axi_araddr_in[7:2], 2'b00})
                PLC_OFF_CTRL:   next_st.rdata = {26'h000_0000, st.ctrl};
                PLC_OFF_STATUS: next_st.rdata = {24'h00_0000, 1'b0, st.fault_latched,
                                                 tx_off_s, st.pins.laser_enable,
                                                 rx_rate_s, tx_rate_s, fault_s, below_s};
                PLC_OFF_IRQ_ST: next_st.rdata = {28'h000_0000, st.irq_st};
                PLC_OFF_IRQ_MK: next_st.rdata = {28'h000_0000, st.irq_mk};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = PLC_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready_in) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st      <= '0;
            st.ctrl <= PLC_CTRL_RST;
            st.irq_mk <= PLC_MASK_RST;
            st.prev_los <= 1'b1;
            // Fault and signal-lost contacts pulled low, ground tie and laser off from reset
            st.pins.fault_pull_low_oe  <= 1'b1;
            st.pins.los_pull_low_oe    <= 1'b1;
            st.pins.missing_tie_low_oe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pins_out          = st.pins;
    assign irq_out           = |(st.irq_st & st.irq_mk);
    assign s_axi_awready_out = !st.aw_held;
    assign s_axi_wready_out  = !st.w_held;
    assign s_axi_bvalid_out  = st.bvalid;
    assign s_axi_bresp_out   = st.bresp;
    assign s_axi_arready_out = !st.rvalid;
    assign s_axi_rvalid_out  = st.rvalid;
    assign s_axi_rdata_out   = st.rdata;
    assign s_axi_rresp_out   = st.rresp;

    property p_off_request;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (tx_off_s && !st.ctrl[PLC_CTRL_PASSIVE]) |=> !st.pins.laser_enable;
    endproperty
    a_off_request: assert property (p_off_request) else $error("laser on while off requested");

    property p_run_normal;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!tx_off_s && !fault_now) |=> st.pins.laser_enable;
    endproperty
    a_run_normal: assert property (p_run_normal) else $error("laser off without cause");

    property p_passive;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.ctrl[PLC_CTRL_PASSIVE] && !fault_now) |=> st.pins.laser_enable;
    endproperty
    a_passive: assert property (p_passive) else $error("passive mode obeyed request");

    sequence s_fault_seen;
        st.ctrl[PLC_CTRL_FAULT_EN] && fault_s;
    endsequence
    property p_fault_flag;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_fault_seen |=> !st.pins.fault_pull_low_oe && !st.pins.laser_enable;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault not flagged");

    property p_no_fault_report;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !st.ctrl[PLC_CTRL_FAULT_EN] |=> st.pins.fault_pull_low_oe;
    endproperty
    a_no_fault_report: assert property (p_no_fault_report) else $error("fault flag not low");

    property p_open_drain;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !st.pins.fault_out && !st.pins.los_out && !st.pins.missing_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("contact driven high");

    property p_missing_tie;
        @(posedge mclk_in) disable iff (!rst_n_in)
        st.pins.missing_tie_low_oe;
    endproperty
    a_missing_tie: assert property (p_missing_tie) else $error("missing flag released");

    property p_los;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.ctrl[PLC_CTRL_LOS_EN] && below_s) |=> !st.pins.los_pull_low_oe;
    endproperty
    a_los: assert property (p_los) else $error("signal loss not flagged");

    property p_rate_rx;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> st.pins.rx_high_rate == ($past(st.ctrl[PLC_CTRL_RATE_EN_RX]) && $past(rx_rate_s));
    endproperty
    a_rate_rx: assert property (p_rate_rx) else $error("receive rate wrong");

    property p_rate_tx;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !tx_rate_s |=> !st.pins.tx_high_rate;
    endproperty
    a_rate_tx: assert property (p_rate_tx) else $error("transmit rate wrong");

    property p_fault_latch;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st.fault_latched && st.ctrl[PLC_CTRL_FAULT_EN]) |=> !st.pins.fault_pull_low_oe;
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("latched fault not flagged");

    property p_fault_laser_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        fault_now |=> !st.pins.laser_enable;
    endproperty
    a_fault_laser_off: assert property (p_fault_laser_off)
        else $error("laser on during fault");

    property p_no_fault_release;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !fault_now |=> st.pins.fault_pull_low_oe;
    endproperty
    a_no_fault_release: assert property (p_no_fault_release)
        else $error("fault contact released");

    // Raw pin to laser: two sync edges, then the output stage
    sequence s_off_pin_seen;
        pins_in.tx_off_request ##2 !st.ctrl[PLC_CTRL_PASSIVE];
    endsequence
    property p_off_pin;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_off_pin_seen |=> !st.pins.laser_enable;
    endproperty
    a_off_pin: assert property (p_off_pin)
        else $error("off request pin not obeyed");

    sequence s_on_pin_seen;
        !pins_in.tx_off_request ##2 !fault_now;
    endsequence
    property p_on_pin;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_on_pin_seen |=> st.pins.laser_enable;
    endproperty
    a_on_pin: assert property (p_on_pin)
        else $error("grounded request left laser off");

    property p_los_unused;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !st.ctrl[PLC_CTRL_LOS_EN] |=> st.pins.los_pull_low_oe;
    endproperty
    a_los_unused: assert property (p_los_unused)
        else $error("unused signal-lost contact released");

    property p_los_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !below_s |=> st.pins.los_pull_low_oe;
    endproperty
    a_los_clear: assert property (p_los_clear)
        else $error("signal lost without cause");

    property p_rate_rx_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !st.ctrl[PLC_CTRL_RATE_EN_RX] |=> !st.pins.rx_high_rate;
    endproperty
    a_rate_rx_off: assert property (p_rate_rx_off)
        else $error("unsupported receive rate steered");

    property p_rate_tx_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !st.ctrl[PLC_CTRL_RATE_EN_TX] |=> !st.pins.tx_high_rate;
    endproperty
    a_rate_tx_off: assert property (p_rate_tx_off)
        else $error("unsupported transmit rate steered");
endmodule
`default_nettype wire

// ---- hdl/plc_dummy_unused.sv ----
`default_nettype none
`default_nettype wire

// ---- test/plc_host_model.sv ----
`default_nettype none
module plc_host_model
    import plc_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    input  wire plc_pkg::plc_pins_out_t pins_in,
    input  wire logic                   off_drive_in,
    input  wire logic                   off_level_in,
    input  wire logic                   rate_drive_in,
    input  wire logic [1:0]             rate_level_in,
    output logic                        tx_off_out,
    output logic [1:0]                  rate_out,
    output logic [2:0]                  seen_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] lvl;
    logic [2:0] meta;
    logic [2:0] sync;
    // Open contact reads through the module pull-up
    assign tx_off_out = off_drive_in ? off_level_in : 1'b1;
    // Undriven selects sink to the weak pull-down; driver tolerates a grounded pin
    assign rate_out = rate_drive_in ? rate_level_in : 2'b00;
    // Host pull-ups: a released contact reads high
    assign lvl[2] = pins_in.fault_pull_low_oe ? pins_in.fault_out : 1'b1;
    assign lvl[1] = pins_in.los_pull_low_oe ? pins_in.los_out : 1'b1;
    assign lvl[0] = pins_in.missing_tie_low_oe ? pins_in.missing_out : 1'b1;
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            meta <= 3'b001;
            sync <= 3'b001;
        end else begin
            meta <= lvl;
            sync <= meta;
        end
    end
    // Empty slot leaves the other contacts floating
    assign seen_out = sync[0] ? 3'b001 : sync;
endmodule
`default_nettype wire

// ---- test/pluggable_module_lowspeed_ctrl_tb_top.sv ----
`default_nettype none
module pluggable_module_lowspeed_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import plc_pkg::*;
    localparam logic [31:0] EV_TX = 32'h0000_0001 << PLC_EV_TX_CHANGE;
    logic mclk, rst_n, irq, tx_off, off_drive, off_level, rate_drive, fault_cond, below;
    logic [1:0] rate, rate_level, bresp, rresp;
    logic [2:0] seen;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    plc_pins_in_t pins;
    plc_pins_out_t pouts;
    int n_errors;
    int tests_run;
    int i;
    assign pins = {tx_off, rate[0], rate[1], fault_cond, below};
    plc_ctrl plc_ctrl_inst (.mclk_in(mclk), .rst_n_in(rst_n), .pins_in(pins),
        .pins_out(pouts), .irq_out(irq), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready));
    plc_host_model plc_host_model_inst (.mclk_in(mclk), .rst_n_in(rst_n), .pins_in(pouts),
        .off_drive_in(off_drive), .off_level_in(off_level), .rate_drive_in(rate_drive),
        .rate_level_in(rate_level), .tx_off_out(tx_off), .rate_out(rate), .seen_out(seen));
    task automatic tally_and_finish;
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Long enough for sync flops plus output stage plus host synchroniser
    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er = PLC_RESP_OK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(32'(bvalid), 32'(1'b1));
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        // Spare edge so the next call never re-drives bready in this step
        @(posedge mclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(32'(rvalid), 32'(1'b1));
        chk(32'(rresp), 32'(er));
        chk(rdata, ed);
        rready <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        n_errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        {off_drive, off_level, rate_drive, fault_cond, below} = 5'b0_0000;
        rate_level = 2'b00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b0_0000;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        axi_rd(PLC_OFF_CTRL, PLC_RESP_OK, 32'(PLC_CTRL_RST));
        axi_rd(PLC_OFF_IRQ_MK, PLC_RESP_OK, 32'(PLC_MASK_RST));
        axi_rd(8'h10, PLC_RESP_SLVERR, 32'h0000_0000);
        settle;
        chk(32'(pouts.laser_enable), 32'(1'b0));
        chk(32'(seen), 32'(3'b000));
        axi_wr(PLC_OFF_IRQ_ST, 32'h0000_000F);
        axi_wr(PLC_OFF_IRQ_MK, EV_TX);
        off_drive <= 1'b1;
        settle;
        chk(32'(pouts.laser_enable), 32'(1'b1));
        chk(32'(irq), 32'(1'b1));
        axi_rd(PLC_OFF_IRQ_ST, PLC_RESP_OK, EV_TX);
        axi_wr(PLC_OFF_IRQ_MK, 32'h0000_0000);
        chk(32'(irq), 32'(1'b0));
        axi_wr(PLC_OFF_IRQ_ST, EV_TX);
        axi_rd(PLC_OFF_IRQ_ST, PLC_RESP_OK, 32'h0000_0000);
        axi_wr(8'h10, 32'h0000_0001, PLC_RESP_SLVERR);
        // Low byte strobe off: the mask must not change
        wstrb <= 4'h0;
        axi_wr(PLC_OFF_IRQ_MK, 32'h0000_000F);
        wstrb <= 4'hF;
        axi_rd(PLC_OFF_IRQ_MK, PLC_RESP_OK, 32'h0000_0000);
        rate_drive <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rate_level <= 2'(i);
            settle;
            chk(32'(pouts.rx_high_rate), 32'(i[0]));
            chk(32'(pouts.tx_high_rate), 32'(i[1]));
        end
        rate_drive <= 1'b0;
        settle;
        chk(32'({pouts.rx_high_rate, pouts.tx_high_rate}), 32'(2'b00));
        rate_drive <= 1'b1;
        axi_wr(PLC_OFF_CTRL, 32'h0000_0003);
        settle;
        chk(32'({pouts.rx_high_rate, pouts.tx_high_rate}), 32'(2'b00));
        axi_wr(PLC_OFF_CTRL, 32'(PLC_CTRL_RST));
        fault_cond <= 1'b1;
        settle;
        chk(32'(seen[2]), 32'(1'b1));
        chk(32'(pouts.laser_enable), 32'(1'b0));
        // Latched fault, request low, laser off, both rate pins high, fault pin high
        axi_rd(PLC_OFF_STATUS, PLC_RESP_OK, 32'h0000_004E);
        // Fault rise, laser change and rate pin change since the last clear
        axi_rd(PLC_OFF_IRQ_ST, PLC_RESP_OK, 32'h0000_000D);
        axi_wr(PLC_OFF_IRQ_ST, 32'h0000_000F);
        fault_cond <= 1'b0;
        settle;
        chk(32'(seen[2]), 32'(1'b1));
        axi_wr(PLC_OFF_CTRL, 32'(PLC_CTRL_RST) | 32'h0000_0020);
        settle;
        chk(32'(seen[2]), 32'(1'b0));
        chk(32'(pouts.laser_enable), 32'(1'b1));
        axi_wr(PLC_OFF_CTRL, 32'h0000_001A);
        fault_cond <= 1'b1;
        settle;
        chk(32'(seen[2]), 32'(1'b0));
        fault_cond <= 1'b0;
        axi_wr(PLC_OFF_CTRL, 32'h0000_001F);
        off_drive <= 1'b0;
        settle;
        chk(32'(pouts.laser_enable), 32'(1'b1));
        below <= 1'b1;
        settle;
        chk(32'(seen[1]), 32'(1'b1));
        below <= 1'b0;
        settle;
        chk(32'(seen[1]), 32'(1'b0));
        // Laser change on fault clear, then signal-lost changes
        axi_rd(PLC_OFF_IRQ_ST, PLC_RESP_OK, 32'h0000_0006);
        axi_wr(PLC_OFF_IRQ_MK, 32'h0000_0002);
        chk(32'(irq), 32'(1'b1));
        tally_and_finish;
    end
endmodule
`default_nettype wire
